// [tsac_defines.svh]
`ifndef TSAC_DEFINES_SVH
`define TSAC_DEFINES_SVH

// register byte offsets
`define TSAC_OFF_CFG 12'h000
`define TSAC_OFF_UPPER 12'h004
`define TSAC_OFF_LOWER 12'h008
`define TSAC_OFF_REMOTE 12'h00c
`define TSAC_OFF_LOCAL 12'h010
`define TSAC_OFF_ONESHOT 12'h014
`define TSAC_OFF_STATUS 12'h018

// configuration field positions
`define TSAC_CFG_MASK_BIT 7
`define TSAC_CFG_STANDBY_BIT 6

// status field positions
`define TSAC_STS_BUSY_BIT 0
`define TSAC_STS_STANDBY_BIT 1
`define TSAC_STS_ALERT_BIT 2
`define TSAC_STS_CNT_LSB 8

// reset values
`define TSAC_RST_CFG 8'h00
`define TSAC_RST_UPPER 8'h46
`define TSAC_RST_LOWER 8'h00
`define TSAC_RST_TEMP 8'h00

// timing
`define TSAC_CLK_PERIOD_NS 10
`define TSAC_CONV_TIME_US 10
`define TSAC_CONV_CYCLES ((`TSAC_CONV_TIME_US * 1000 + `TSAC_CLK_PERIOD_NS - 1) / `TSAC_CLK_PERIOD_NS)

`endif

// [tsac_pkg.sv]
package tsac_pkg;

  // conversion sequencer states
  typedef enum logic [0:0] {
    TSAC_IDLE,
    TSAC_CONV
  } tsac_state_t;

  // configuration register layout
  typedef struct packed {
    logic mask;
    logic standby;
    logic [5:0] reserved_bits;
  } tsac_cfg_t;

  // one pair of conversion results, two's complement degrees
  typedef struct packed {
    logic [7:0] remote;
    logic [7:0] internal;
  } tsac_temps_t;

  // alarm window limits
  typedef struct packed {
    logic [7:0] upper;
    logic [7:0] lower;
  } tsac_limits_t;

endpackage

// [tsac_window_cmp.sv]
`timescale 1ns/1ps
// signed window check of one temperature against the limits
module tsac_window_cmp
  import tsac_pkg::*;
(
  input wire logic [7:0] temp_i,
  input wire tsac_limits_t limits_i,
  output logic out_of_window_o
);

  // strict compares: equality with a limit stays quiet
  always_comb begin
    out_of_window_o = ($signed(temp_i) > $signed(limits_i.upper)) ||
                      ($signed(temp_i) < $signed(limits_i.lower)); // R1 R2
  end

endmodule

// [tsac_top.sv]
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "tsac_defines.svh"
// How it works
// R1: alert asserts when remote or internal temperature is above upper or below lower.
// R2: equality with a limit may alert; this design stays quiet on equality.
// R3: standby bit 6 low means continuous back-to-back conversions.
// R4: writing standby bit high aborts a running conversion at once.
// R5: in standby each one-shot command runs exactly one conversion; this design ignores one written while a conversion runs.
// R6: host must not trust one-shot results issued during auto-convert mode.
// R7: mask bit 7 high holds the alert output released.
// R8: host writes zero to reserved bits 5..0 and ignores them on read.
// R9: host should keep auto-convert mode while watching processor temperature.
// R10: alert comparison refreshes after every completed conversion, both modes.
module tsac_top
  import tsac_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // sensing front end, asynchronous to clk_i
  input wire logic [7:0] remote_temp_i,
  input wire logic [7:0] internal_temp_i,
  // open-drain alert pin
  output logic smbalert_out_o,
  output logic smbalert_oe_o,
  // conversion activity for the front end
  output logic conv_active_o
);

  localparam logic [15:0] CONV_CYCLES = 16'(`TSAC_CONV_CYCLES);

  // address decode shared by read and write paths
  function automatic logic addr_known(input logic [11:0] a);
    begin
      addr_known = (a == `TSAC_OFF_CFG) || (a == `TSAC_OFF_UPPER) || (a == `TSAC_OFF_LOWER) ||
                   (a == `TSAC_OFF_REMOTE) || (a == `TSAC_OFF_LOCAL) ||
                   (a == `TSAC_OFF_ONESHOT) || (a == `TSAC_OFF_STATUS);
    end
  endfunction

  tsac_cfg_t cfg_reg;
  tsac_limits_t limits_reg;
  tsac_temps_t temps_reg;
  tsac_state_t state_reg;
  logic [15:0] cnt_reg;
  logic alert_reg;
  logic [7:0] conv_cnt_reg;
  logic [7:0] remote_s1_reg;
  logic [7:0] remote_s2_reg;
  logic [7:0] internal_s1_reg;
  logic [7:0] internal_s2_reg;
  logic [7:0] remote_s3_reg;
  logic [7:0] internal_s3_reg;
  logic [7:0] remote_held_reg;
  logic [7:0] internal_held_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic smbalert_oe_reg;
  logic conv_active_reg;

  logic apb_setup;
  logic apb_done;
  logic wr_cfg;
  logic wr_oneshot;
  logic conv_end;
  logic remote_oow;
  logic internal_oow;
  logic [31:0] rd_mux;

  // apb phases; no wait state, yet read data leave a flip-flop
  assign apb_setup = psel_i && !penable_i;
  assign apb_done = psel_i && penable_i && pready_reg;
  assign wr_cfg = apb_done && pwrite_i && (paddr_i == `TSAC_OFF_CFG);
  assign wr_oneshot = apb_done && pwrite_i && (paddr_i == `TSAC_OFF_ONESHOT);
  assign conv_end = (state_reg == TSAC_CONV) && (cnt_reg == CONV_CYCLES - 16'h0001);

  // two-flop synchronisers for the front-end results
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      remote_s1_reg <= 8'h00;
      remote_s2_reg <= 8'h00;
      internal_s1_reg <= 8'h00;
      internal_s2_reg <= 8'h00;
      remote_s3_reg <= 8'h00;
      internal_s3_reg <= 8'h00;
    end else begin
      remote_s1_reg <= remote_temp_i;
      remote_s2_reg <= remote_s1_reg;
      internal_s1_reg <= internal_temp_i;
      internal_s2_reg <= internal_s1_reg;
      remote_s3_reg <= remote_s2_reg;
      internal_s3_reg <= internal_s2_reg;
    end
  end

  // a word is taken only when two settled samples agree, so a reading caught
  // mid-change on its bits never reaches the results; costs two cycles of latency
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      remote_held_reg <= `TSAC_RST_TEMP;
      internal_held_reg <= `TSAC_RST_TEMP;
    end else begin
      if (remote_s2_reg == remote_s3_reg) begin
        remote_held_reg <= remote_s3_reg;
      end
      if (internal_s2_reg == internal_s3_reg) begin
        internal_held_reg <= internal_s3_reg;
      end
    end
  end

  // configuration; reserved bits are never stored, so they read zero
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cfg_reg <= `TSAC_RST_CFG;
    end else if (wr_cfg) begin
      cfg_reg.mask <= pwdata_i[`TSAC_CFG_MASK_BIT];
      cfg_reg.standby <= pwdata_i[`TSAC_CFG_STANDBY_BIT];
      cfg_reg.reserved_bits <= 6'h00;
    end
  end

  // alarm limits
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      limits_reg.upper <= `TSAC_RST_UPPER;
      limits_reg.lower <= `TSAC_RST_LOWER;
    end else if (apb_done && pwrite_i) begin
      if (paddr_i == `TSAC_OFF_UPPER) begin
        limits_reg.upper <= pwdata_i[7:0];
      end
      if (paddr_i == `TSAC_OFF_LOWER) begin
        limits_reg.lower <= pwdata_i[7:0];
      end
    end
  end

  // conversion sequencer
  // a standby write wins over everything, even a conversion about to finish
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      state_reg <= TSAC_IDLE;
      cnt_reg <= 16'h0000;
    end else if (wr_cfg && pwdata_i[`TSAC_CFG_STANDBY_BIT]) begin
      state_reg <= TSAC_IDLE; // R4
      cnt_reg <= 16'h0000;
    end else begin
      case (state_reg)
        TSAC_IDLE: begin
          cnt_reg <= 16'h0000;
          if (!cfg_reg.standby) begin
            state_reg <= TSAC_CONV; // R3
          end else if (wr_oneshot) begin
            state_reg <= TSAC_CONV; // R5
          end
        end
        TSAC_CONV: begin
          if (conv_end) begin
            cnt_reg <= 16'h0000;
            // auto mode restarts directly, standby returns to idle
            state_reg <= cfg_reg.standby ? TSAC_IDLE : TSAC_CONV; // R3 R5
          end else begin
            cnt_reg <= cnt_reg + 16'h0001;
          end
        end
        default: begin
          state_reg <= TSAC_IDLE;
          cnt_reg <= 16'h0000;
        end
      endcase
    end
  end

  // results latched only when a conversion completes; an aborted one leaves them alone
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      temps_reg.remote <= `TSAC_RST_TEMP;
      temps_reg.internal <= `TSAC_RST_TEMP;
      conv_cnt_reg <= 8'h00;
    end else if (conv_end && !(wr_cfg && pwdata_i[`TSAC_CFG_STANDBY_BIT])) begin
      temps_reg.remote <= remote_held_reg;
      temps_reg.internal <= internal_held_reg;
      conv_cnt_reg <= conv_cnt_reg + 8'h01;
    end
  end

  // one comparator per measured channel
  tsac_window_cmp u_cmp_remote (
    .temp_i(temps_reg.remote),
    .limits_i(limits_reg),
    .out_of_window_o(remote_oow)
  );

  tsac_window_cmp u_cmp_internal (
    .temp_i(temps_reg.internal),
    .limits_i(limits_reg),
    .out_of_window_o(internal_oow)
  );

  // alert state follows the latest results and the current limits
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      alert_reg <= 1'b0;
    end else begin
      alert_reg <= remote_oow || internal_oow; // R1 R10
    end
  end

  // open-drain pin: only ever pulls low, mask releases it
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      smbalert_oe_reg <= 1'b0;
    end else begin
      smbalert_oe_reg <= alert_reg && !cfg_reg.mask; // R7
    end
  end

  // front end told when a conversion window is open
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      conv_active_reg <= 1'b0;
    end else begin
      conv_active_reg <= (state_reg == TSAC_CONV);
    end
  end

  // read mux; write-only one-shot reads zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr_i)
      `TSAC_OFF_CFG: rd_mux[7:0] = cfg_reg;
      `TSAC_OFF_UPPER: rd_mux[7:0] = limits_reg.upper;
      `TSAC_OFF_LOWER: rd_mux[7:0] = limits_reg.lower;
      `TSAC_OFF_REMOTE: rd_mux[7:0] = temps_reg.remote;
      `TSAC_OFF_LOCAL: rd_mux[7:0] = temps_reg.internal;
      `TSAC_OFF_STATUS: begin
        rd_mux[`TSAC_STS_BUSY_BIT] = (state_reg == TSAC_CONV);
        rd_mux[`TSAC_STS_STANDBY_BIT] = cfg_reg.standby;
        rd_mux[`TSAC_STS_ALERT_BIT] = alert_reg;
        rd_mux[`TSAC_STS_CNT_LSB +: 8] = conv_cnt_reg;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // apb answer: ready in the first cycle of the access phase
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else if (apb_setup) begin
      pready_reg <= 1'b1;
      pslverr_reg <= !addr_known(paddr_i);
      prdata_reg <= pwrite_i ? 32'h0000_0000 : rd_mux;
    end else begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end
  end

  assign prdata_o = prdata_reg;
  assign pready_o = pready_reg;
  assign pslverr_o = pslverr_reg;
  assign smbalert_out_o = 1'b0;
  assign smbalert_oe_o = smbalert_oe_reg;
  assign conv_active_o = conv_active_reg;

endmodule

// [tsac_host_model.sv]
`timescale 1ns/1ps
// sensing front end plus the host side of the alert line
module tsac_host_model (
  input wire logic clk_i,
  input wire logic [7:0] rem_i,
  input wire logic [7:0] loc_i,
  input wire logic out_i,
  input wire logic oe_i,
  output logic [7:0] rem_o = 8'h00,
  output logic [7:0] loc_o = 8'h00,
  output logic line_o
);
  // readings move only on an edge, like a real converter
  always @(posedge clk_i) begin
    rem_o <= rem_i;
    loc_o <= loc_i;
  end
  // pull-up: a released line reads high, never the last level
  assign line_o = oe_i ? out_i : 1'b1;
endmodule

// [tsac_chk.sv]
`timescale 1ns/1ps
`include "tsac_defines.svh"
// watches the pins, shadows writable fields from apb writes
module tsac_chk (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic pready_o,
  input wire logic [7:0] remote_temp_i,
  input wire logic [7:0] internal_temp_i,
  input wire logic smbalert_oe_o,
  input wire logic conv_active_o
);
  logic mask_q, stby_q;
  logic [7:0] up_q, lo_q, rt_q, it_q;
  logic [2:0] stab_q;
  logic [10:0] run_q;
  wire wr_done = psel_i && penable_i && pready_o && pwrite_i;
  wire stop_wr = wr_done && paddr_i == `TSAC_OFF_CFG && pwdata_i[6];
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // limits passed in so the sampled values are used, not ones updated at the edge
  function automatic logic outside(input logic [7:0] t, input logic [7:0] up, input logic [7:0] lo);
    return $signed(t) > $signed(up) || $signed(t) < $signed(lo);
  endfunction
  // register shadow
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      mask_q <= 1'b0;
      stby_q <= 1'b0;
      up_q <= `TSAC_RST_UPPER;
      lo_q <= `TSAC_RST_LOWER;
    end else if (wr_done) begin
      if (paddr_i == `TSAC_OFF_CFG) begin
        mask_q <= pwdata_i[7];
        stby_q <= pwdata_i[6];
      end
      if (paddr_i == `TSAC_OFF_UPPER) up_q <= pwdata_i[7:0];
      if (paddr_i == `TSAC_OFF_LOWER) lo_q <= pwdata_i[7:0];
    end
  end
  // length of the running conversion
  always_ff @(posedge clk_i) begin
    if (!rstn_i || !conv_active_o) run_q <= 11'h000;
    else run_q <= run_q + 11'h001;
  end
  // age of the readings; the synchroniser hides younger changes
  always_ff @(posedge clk_i) begin
    rt_q <= remote_temp_i;
    it_q <= internal_temp_i;
    if (!rstn_i || rt_q != remote_temp_i || it_q != internal_temp_i) stab_q <= 3'h0;
    else if (stab_q != 3'h7) stab_q <= stab_q + 3'h1;
  end
  sequence s_cfg_wr;
    wr_done && paddr_i == `TSAC_OFF_CFG;
  endsequence
  sequence s_done;
    $fell(conv_active_o) && run_q == `TSAC_CONV_CYCLES;
  endsequence
  property p_ready;
    psel_i && !penable_i |=> pready_o;
  endproperty
  a_ready: assert property (p_ready) else $error("access not answered");
  property p_mask_now;
    s_cfg_wr ##0 pwdata_i[7] |-> ##2 !smbalert_oe_o;
  endproperty
  a_mask_now: assert property (p_mask_now) else $error("mask write kept alert");
  property p_masked;
    mask_q && $past(mask_q) |-> !smbalert_oe_o;
  endproperty
  a_masked: assert property (p_masked) else $error("alert while masked");
  property p_abort;
    s_cfg_wr ##0 pwdata_i[6] |-> ##2 !conv_active_o;
  endproperty
  a_abort: assert property (p_abort) else $error("stop did not abort");
  property p_auto;
    !stby_q && !$past(stby_q) && !$past(stby_q, 2) && $past(rstn_i) && $past(rstn_i, 2) |-> conv_active_o;
  endproperty
  a_auto: assert property (p_auto) else $error("auto mode stalled");
  property p_len;
    $fell(conv_active_o) && !$past(stop_wr, 2) |-> run_q == `TSAC_CONV_CYCLES;
  endproperty
  a_len: assert property (p_len) else $error("wrong conversion length");
  property p_oneshot;
    wr_done && paddr_i == `TSAC_OFF_ONESHOT && stby_q && !conv_active_o |-> ##2 conv_active_o [*8];
  endproperty
  a_oneshot: assert property (p_oneshot) else $error("one-shot not started");
  property p_alert;
    s_done ##0 (stab_q == 3'h7 && !mask_q) |->
      ##[1:3] smbalert_oe_o == (outside(remote_temp_i, up_q, lo_q) || outside(internal_temp_i, up_q, lo_q));
  endproperty
  a_alert: assert property (p_alert) else $error("alert level wrong");
endmodule
bind tsac_top tsac_chk u_chk (.clk_i, .rstn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
  .pready_o, .remote_temp_i, .internal_temp_i, .smbalert_oe_o, .conv_active_o);

// [tsac_top_test.sv]
`timescale 1ns/1ps
`include "tsac_defines.svh"
module tsac_top_test;
  logic clk_i = 1'b0, rstn_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0, prdata_o, q;
  logic pready_o, pslverr_o, smbalert_out_o, smbalert_oe_o, conv_active_o, line, e;
  logic [7:0] remote_temp_i, internal_temp_i, cnt, rset = 8'h20, iset = 8'h20;
  int n_errors = 0, cmp_count = 0;
  initial forever #5 clk_i = ~clk_i;
  tsac_top DUT (.clk_i, .rstn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
    .pslverr_o, .remote_temp_i, .internal_temp_i, .smbalert_out_o, .smbalert_oe_o, .conv_active_o);
  tsac_host_model u_host (.clk_i, .rem_i(rset), .loc_i(iset), .out_i(smbalert_out_o),
    .oe_i(smbalert_oe_o), .rem_o(remote_temp_i), .loc_o(internal_temp_i), .line_o(line));
  task automatic conclude();
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] got);
    cmp_count++;
    if (got !== x) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, x, got);
    end
  endtask
  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    if (n >= 50) chk("pready", 32'h1, 32'h0);
    q = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask
  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] x, input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    chk(nm, x, q & m);
  endtask
  task automatic al(input string nm, input logic x);
    chk(nm, {31'h0, x}, {31'h0, line});
  endtask
  // main sequence; reserved config bits always written as zero
  initial begin
    repeat (10) @(posedge clk_i);
    rstn_i <= 1'b1;
    rd("cfg", `TSAC_OFF_CFG, 32'h0, 32'hffffffff);
    apb(1'b0, 12'hffc, 32'h0);
    chk("unmapped", 32'h1, {31'h0, e});
    rset <= 8'h47;
    repeat (2200) @(posedge clk_i);
    al("above", 1'b0);
    wr(`TSAC_OFF_CFG, 8'h80);
    repeat (2) @(posedge clk_i);
    al("masked", 1'b1);
    rd("cfg mask", `TSAC_OFF_CFG, 32'h80, 32'hffffffff);
    wr(`TSAC_OFF_CFG, 8'h00);
    repeat (3) @(posedge clk_i);
    al("unmasked", 1'b0);
    rset <= 8'h46;
    repeat (2200) @(posedge clk_i);
    al("equal", 1'b1);
    iset <= 8'hff;
    repeat (2500) @(posedge clk_i);
    al("below", 1'b0);
    wr(`TSAC_OFF_CFG, 8'h40);
    rd("busy stop", `TSAC_OFF_STATUS, 32'h0, 32'h1);
    cnt = q[15:8];
    iset <= 8'h20;
    repeat (2200) @(posedge clk_i);
    al("frozen", 1'b0);
    rd("cnt idle", `TSAC_OFF_STATUS, {16'h0, cnt, 8'h00}, 32'hff00);
    wr(`TSAC_OFF_ONESHOT, 8'h00);
    rd("busy shot", `TSAC_OFF_STATUS, 32'h1, 32'h1);
    repeat (1100) @(posedge clk_i);
    rd("cnt shot", `TSAC_OFF_STATUS, {16'h0, cnt + 8'h01, 8'h00}, 32'hff01);
    al("shot", 1'b1);
    wr(`TSAC_OFF_CFG, 8'h00);
    repeat (5) @(posedge clk_i);
    rd("busy auto", `TSAC_OFF_STATUS, 32'h1, 32'h1);
    conclude();
  end
  // watchdog well beyond the ten thousand cycles used
  initial begin
    repeat (30000) @(posedge clk_i);
    n_errors++;
    conclude();
  end
endmodule
